// file: hdl/dht_timer.sv
// Dual half timer: two 16-bit counters, joined 32-bit timer or clock
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module dht_timer (
  input  logic              ref_clk,
  input  logic              rst,
  input  dht_pkg::dht_bus_s bus_req,
  output logic [31:0]       bus_rdata,
  input  logic              capture_pin_a,
  input  logic              capture_pin_b,
  input  logic              debug_halt,
  output logic              conv_trigger,
  output logic              int_req
);
  import dht_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [2:0]  cfg_reg;
  dht_mode_s   mode_reg [2];
  dht_ctl_s    ctl_reg [2];
  logic        ovr_reg;
  logic [15:0] mask_reg;
  logic [15:0] raw_reg;
  logic [15:0] evt;
  logic [15:0] clr_bits;
  logic [15:0] ilr_reg [2];
  logic [15:0] match_reg [2];
  logic [15:0] cnt_reg [2];
  logic [15:0] cnt_next [2];
  logic [7:0]  pre_reg [2];
  logic [7:0]  pcnt_reg [2];
  logic [7:0]  pcnt_next [2];
  logic [15:0] ilr_wd [2];
  logic [15:0] match_wd [2];
  logic [1:0]  ilr_we;
  logic [1:0]  match_we;
  logic [1:0]  to_evt;
  logic [1:0]  cm_evt;
  logic [1:0]  en_clr;
  logic [1:0]  frz;
  logic [1:0]  pins;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  pin_edge;
  logic [2:0]  sync_reg [2];
  logic [14:0] rtc_div_reg;
  logic [31:0] full;
  logic [31:0] full_ilr;
  logic [31:0] full_match;
  logic [15:0] dec;
  logic        rtc_evt;
  logic        rtc_tick;
  logic        rtc_select;
  logic        rtc_frz;
  logic        wide;
  logic        split;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;

  assign wr    = bus_req.wr;
  assign addr  = bus_req.addr;
  assign wdata = bus_req.wdata;
  assign pins  = {capture_pin_b, capture_pin_a};
  assign wide  = (cfg_reg == CFG_32) || (cfg_reg == CFG_RTC);
  assign split = (cfg_reg == CFG_SPLIT);
  assign full       = {cnt_reg[1], cnt_reg[0]};
  assign full_ilr   = {ilr_reg[1], ilr_reg[0]};
  assign full_match = {match_reg[1], match_reg[0]};

  // ************************************************************
  // Pin synchronisers and edge select
  // ************************************************************

  // Stage 0 feeds stage 1 only; stage 2 is history for edges
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        sync_reg[i] <= 3'h0;
      end else begin
        sync_reg[i] <= {sync_reg[i][1:0], pins[i]};
      end
    end
  end

  // Edges need two-clock pin levels to be seen reliably
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rise[i] = sync_reg[i][1] & ~sync_reg[i][2];
      fall[i] = ~sync_reg[i][1] & sync_reg[i][2];
      case (ctl_reg[i].half_edge_select)
        EDGE_RISE: pin_edge[i] = rise[i];
        EDGE_FALL: pin_edge[i] = fall[i];
        EDGE_BOTH: pin_edge[i] = rise[i] | fall[i];
        default:   pin_edge[i] = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Real-time clock divider
  // ************************************************************

  // Counts rising edges of pin A; one tick per RTC_DIV edges
  always_ff @(posedge ref_clk) begin
    if (rst || cfg_reg != CFG_RTC) begin
      rtc_div_reg <= 15'h0000;
    end else if (rise[0]) begin
      if (rtc_div_reg == RTC_DIV_LAST) begin
        rtc_div_reg <= 15'h0000;
      end else begin
        rtc_div_reg <= rtc_div_reg + 15'h0001;
      end
    end
  end

  assign rtc_tick = (cfg_reg == CFG_RTC) && rise[0] && (rtc_div_reg == RTC_DIV_LAST);

  // ************************************************************
  // Write decode
  // ************************************************************

  // In joined modes a half A load or match write also covers half B
  always_comb begin
    ilr_we[0]   = wr && (addr == ILR_A_OFS);
    ilr_we[1]   = wr && ((addr == ILR_B_OFS) || ((addr == ILR_A_OFS) && wide));
    ilr_wd[0]   = wdata[15:0];
    ilr_wd[1]   = (addr == ILR_A_OFS) ? wdata[31:16] : wdata[15:0];
    match_we[0] = wr && (addr == MATCH_A_OFS);
    match_we[1] = wr && ((addr == MATCH_B_OFS) || ((addr == MATCH_A_OFS) && wide));
    match_wd[0] = wdata[15:0];
    match_wd[1] = (addr == MATCH_A_OFS) ? wdata[31:16] : wdata[15:0];
    clr_bits    = (wr && addr == CLR_OFS) ? wdata[15:0] : 16'h0000;
    rtc_select  = wr && (addr == CFG_OFS) && (wdata[2:0] == CFG_RTC)
                  && (cfg_reg != CFG_RTC);
  end

  // ************************************************************
  // Counting engine
  // ************************************************************

  assign frz[0]  = debug_halt & ctl_reg[0].half_debug_freeze;
  assign frz[1]  = debug_halt & ctl_reg[1].half_debug_freeze;
  assign rtc_frz = debug_halt & (|frz) & ~ovr_reg;

  // Next counts and events; load writes outside clock mode override the counts in the flops
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cnt_next[i]  = cnt_reg[i];
      pcnt_next[i] = pcnt_reg[i];
    end
    to_evt  = 2'b00;
    cm_evt  = 2'b00;
    en_clr  = 2'b00;
    rtc_evt = 1'b0;
    dec     = 16'h0000;
    if (cfg_reg == CFG_32) begin
      if (ctl_reg[0].half_enable && !frz[0]) begin
        if (full == 32'h0000_0000) begin
          {cnt_next[1], cnt_next[0]} = full_ilr;
          to_evt[0] = 1'b1;
          if (mode_reg[0].half_mode_field == MODE_ONESHOT) begin
            en_clr[0] = 1'b1;
          end
        end else begin
          {cnt_next[1], cnt_next[0]} = full - 32'h0000_0001;
        end
      end
    end else if (cfg_reg == CFG_RTC) begin
      if (ctl_reg[0].half_enable && rtc_tick && !rtc_frz) begin
        if (full == full_match) begin
          {cnt_next[1], cnt_next[0]} = 32'h0000_0000;
          rtc_evt = 1'b1;
        end else begin
          {cnt_next[1], cnt_next[0]} = full + 32'h0000_0001;
        end
      end
    end else if (split) begin
      // Each half on its own, any mode combination
      for (int i = 0; i < 2; i++) begin
        if (ctl_reg[i].half_enable && !frz[i]) begin
          if (mode_reg[i].half_mode_field == MODE_ONESHOT ||
              mode_reg[i].half_mode_field == MODE_PERIODIC) begin
            if (pcnt_reg[i] != PRE_RST) begin
              pcnt_next[i] = pcnt_reg[i] - 8'h01;
            end else if (cnt_reg[i] == 16'h0000) begin
              cnt_next[i]  = ilr_reg[i];
              pcnt_next[i] = pre_reg[i];
              to_evt[i]    = 1'b1;
              if (mode_reg[i].half_mode_field == MODE_ONESHOT) begin
                en_clr[i] = 1'b1;
              end
            end else begin
              cnt_next[i]  = cnt_reg[i] - 16'h0001;
              pcnt_next[i] = pre_reg[i];
            end
          end else if (mode_reg[i].half_mode_field == MODE_CAPTURE &&
                       !mode_reg[i].half_capture_mode && pin_edge[i]) begin
            // Edge count ignores the prescaler
            dec = cnt_reg[i] - 16'h0001;
            if (dec == match_reg[i]) begin
              cnt_next[i] = ilr_reg[i];
              cm_evt[i]   = 1'b1;
              en_clr[i]   = 1'b1;
            end else begin
              cnt_next[i] = dec;
            end
          end
        end
      end
    end
  end

  // Counter flops; outside clock mode a load write wins so the new value runs next
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        cnt_reg[i]  <= CNT_RST;
        pcnt_reg[i] <= PRE_RST;
      end else if (rtc_select) begin
        cnt_reg[i]  <= (i == 0) ? RTC_START : 16'h0000;
        pcnt_reg[i] <= PRE_RST;
      end else if (ilr_we[i] && cfg_reg != CFG_RTC) begin
        cnt_reg[i]  <= ilr_wd[i];
        pcnt_reg[i] <= pcnt_next[i];
      end else begin
        cnt_reg[i]  <= cnt_next[i];
        pcnt_reg[i] <= pcnt_next[i];
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************

  // Configuration, modes and mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg     <= CFG_32;
      mode_reg[0] <= '0;
      mode_reg[1] <= '0;
      mask_reg    <= 16'h0000;
    end else if (wr) begin
      if (addr == CFG_OFS) begin
        cfg_reg <= wdata[2:0];
      end else if (addr == MODE_A_OFS) begin
        mode_reg[0] <= dht_mode_s'(wdata[2:0]);
      end else if (addr == MODE_B_OFS) begin
        mode_reg[1] <= dht_mode_s'(wdata[2:0]);
      end else if (addr == MASK_OFS) begin
        mask_reg <= wdata[15:0];
      end
    end
  end

  // Control; a software write beats the hardware clear of enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_reg[0] <= '0;
      ctl_reg[1] <= '0;
      ovr_reg    <= 1'b0;
    end else if (wr && addr == CTL_OFS) begin
      ctl_reg[0] <= dht_ctl_s'(wdata[4:0]);
      ctl_reg[1] <= dht_ctl_s'(wdata[CTL_B_LSB +: 5]);
      ovr_reg    <= wdata[CTL_OVR_BIT];
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (en_clr[i]) begin
          ctl_reg[i].half_enable <= 1'b0;
        end
      end
    end
  end

  // Load, match and prescale values
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        ilr_reg[i]   <= CNT_RST;
        match_reg[i] <= CNT_RST;
        pre_reg[i]   <= PRE_RST;
      end else begin
        if (ilr_we[i]) begin
          ilr_reg[i] <= ilr_wd[i];
        end
        if (match_we[i]) begin
          match_reg[i] <= match_wd[i];
        end
        if (wr && addr == (i == 0 ? PRE_A_OFS : PRE_B_OFS)) begin
          pre_reg[i] <= wdata[7:0];
        end
      end
    end
  end

  // ************************************************************
  // Status, interrupt and trigger
  // ************************************************************

  always_comb begin
    evt = 16'h0000;
    evt[TO_BIT]               = to_evt[0];
    evt[CM_BIT]               = cm_evt[0];
    evt[RTC_BIT]              = rtc_evt;
    evt[TO_BIT + HALF_STRIDE] = to_evt[1];
    evt[CM_BIT + HALF_STRIDE] = cm_evt[1];
  end

  // Sticky flags; a new event in the clear cycle survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw_reg <= 16'h0000;
    end else begin
      raw_reg <= (raw_reg & ~clr_bits) | evt;
    end
  end

  // Masked view drives the controller interrupt
  assign int_req = |(raw_reg & mask_reg);

  // Trigger is gated only by its enable, not by the mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_trigger <= 1'b0;
    end else begin
      conv_trigger <= (to_evt[0] & ctl_reg[0].half_conv_trigger_en) |
                      (to_evt[1] & ctl_reg[1].half_conv_trigger_en);
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************

  // Data valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      if (addr == CFG_OFS) begin
        bus_rdata <= 32'(cfg_reg);
      end else if (addr == MODE_A_OFS) begin
        bus_rdata <= 32'(mode_reg[0]);
      end else if (addr == MODE_B_OFS) begin
        bus_rdata <= 32'(mode_reg[1]);
      end else if (addr == CTL_OFS) begin
        bus_rdata <= 32'({ctl_reg[1], 1'b0, ovr_reg, 1'b0, ctl_reg[0]});
      end else if (addr == MASK_OFS) begin
        bus_rdata <= 32'(mask_reg);
      end else if (addr == RAW_OFS) begin
        bus_rdata <= 32'(raw_reg);
      end else if (addr == MIS_OFS) begin
        bus_rdata <= 32'(raw_reg & mask_reg);
      end else if (addr == ILR_A_OFS) begin
        bus_rdata <= wide ? full_ilr : 32'(ilr_reg[0]);
      end else if (addr == ILR_B_OFS) begin
        bus_rdata <= 32'(ilr_reg[1]);
      end else if (addr == MATCH_A_OFS) begin
        bus_rdata <= wide ? full_match : 32'(match_reg[0]);
      end else if (addr == MATCH_B_OFS) begin
        bus_rdata <= 32'(match_reg[1]);
      end else if (addr == PRE_A_OFS) begin
        bus_rdata <= 32'(pre_reg[0]);
      end else if (addr == PRE_B_OFS) begin
        bus_rdata <= 32'(pre_reg[1]);
      end else if (addr == CNT_A_OFS) begin
        bus_rdata <= wide ? full : 32'(cnt_reg[0]);
      end else if (addr == CNT_B_OFS) begin
        bus_rdata <= 32'(cnt_reg[1]);
      end else begin
        bus_rdata <= 32'h0000_0000;
      end
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  a_reset_state:
    assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> cnt_reg[0] == CNT_RST && cnt_reg[1] == CNT_RST &&
      ilr_reg[1] == CNT_RST && pcnt_reg[0] == PRE_RST && cfg_reg == CFG_32)
    else $error("state after reset wrong");

  a_joined_halves:
    assert property (@(posedge ref_clk) disable iff (rst)
      !split |-> to_evt[1] == 1'b0 && cm_evt == 2'b00)
    else $error("half event outside split mode");

  a_wide_write:
    assert property (@(posedge ref_clk) disable iff (rst)
      (wr && addr == ILR_A_OFS && wide) |=>
      full_ilr == $past(wdata))
    else $error("wide load write split wrong");

  a_wide_read:
    assert property (@(posedge ref_clk) disable iff (rst)
      (bus_req.rd && addr == CNT_A_OFS && wide) |=> bus_rdata == $past(full))
    else $error("wide count read wrong");

  a_wide_reload:
    assert property (@(posedge ref_clk) disable iff (rst)
      (cfg_reg == CFG_32 && ctl_reg[0].half_enable && !frz[0] &&
       full == 32'h0000_0000 && ilr_we == 2'b00 && !rtc_select) |=>
      full == $past(full_ilr) && raw_reg[TO_BIT])
    else $error("joined reload or flag missing");

  a_oneshot_stop:
    assert property (@(posedge ref_clk) disable iff (rst)
      (to_evt[0] && mode_reg[0].half_mode_field == MODE_ONESHOT &&
       !(wr && addr == CTL_OFS)) |=> !ctl_reg[0].half_enable)
    else $error("one-shot kept running");

  a_flag_hold:
    assert property (@(posedge ref_clk) disable iff (rst)
      (raw_reg[TO_BIT] && !clr_bits[TO_BIT]) |=> raw_reg[TO_BIT])
    else $error("time-out flag lost");

  a_trigger_gate:
    assert property (@(posedge ref_clk) disable iff (rst)
      conv_trigger |-> $past((to_evt[0] && ctl_reg[0].half_conv_trigger_en) ||
                             (to_evt[1] && ctl_reg[1].half_conv_trigger_en)))
    else $error("trigger without enabled time-out");

  a_load_write:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ilr_we[0] && cfg_reg == CFG_32) |=> cnt_reg[0] == $past(wdata[15:0]))
    else $error("written load not in counter");

  a_debug_freeze:
    assert property (@(posedge ref_clk) disable iff (rst)
      (cfg_reg == CFG_32 && frz[0] && !wr) |=> full == $past(full))
    else $error("counter moved while frozen");

  a_clock_start:
    assert property (@(posedge ref_clk) disable iff (rst)
      rtc_select |=> full == 32'h0000_0001)
    else $error("clock mode did not start at one");

  a_clock_roll:
    assert property (@(posedge ref_clk) disable iff (rst)
      rtc_evt |=> full == 32'h0000_0000 && raw_reg[RTC_BIT])
    else $error("clock match did not roll over");

  a_clock_override:
    assert property (@(posedge ref_clk) disable iff (rst)
      (cfg_reg == CFG_RTC && ctl_reg[0].half_enable && rtc_tick && ovr_reg &&
       full != full_match && !wr) |=> full == $past(full) + 32'h0000_0001)
    else $error("clock stalled despite override");

  a_prescale_step:
    assert property (@(posedge ref_clk) disable iff (rst)
      (split && ctl_reg[0].half_enable && !frz[0] && !wr &&
       mode_reg[0].half_mode_field == MODE_PERIODIC && pcnt_reg[0] != PRE_RST)
      |=> cnt_reg[0] == $past(cnt_reg[0]) &&
          pcnt_reg[0] == $past(pcnt_reg[0]) - 8'h01)
    else $error("prescaler step wrong");

  a_edge_match:
    assert property (@(posedge ref_clk) disable iff (rst)
      (cm_evt[0] && !wr) |=> !ctl_reg[0].half_enable && raw_reg[CM_BIT] &&
      cnt_reg[0] == $past(ilr_reg[0]))
    else $error("edge match handling wrong");

endmodule

// file: pkg/dht_pkg.sv
// Package: register map, field layouts, modes and constants of the timer
package dht_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CFG_OFS     = 8'h00;
  localparam logic [7:0] MODE_A_OFS  = 8'h04;
  localparam logic [7:0] MODE_B_OFS  = 8'h08;
  localparam logic [7:0] CTL_OFS     = 8'h0C;
  localparam logic [7:0] MASK_OFS    = 8'h10;
  localparam logic [7:0] RAW_OFS     = 8'h14;
  localparam logic [7:0] MIS_OFS     = 8'h18;
  localparam logic [7:0] CLR_OFS     = 8'h1C;
  localparam logic [7:0] ILR_A_OFS   = 8'h20;
  localparam logic [7:0] ILR_B_OFS   = 8'h24;
  localparam logic [7:0] MATCH_A_OFS = 8'h28;
  localparam logic [7:0] MATCH_B_OFS = 8'h2C;
  localparam logic [7:0] PRE_A_OFS   = 8'h30;
  localparam logic [7:0] PRE_B_OFS   = 8'h34;
  localparam logic [7:0] CNT_A_OFS   = 8'h38;
  localparam logic [7:0] CNT_B_OFS   = 8'h3C;

  // ************************************************************
  // Configuration values and field positions
  // ************************************************************
  localparam logic [2:0] CFG_32    = 3'h0;
  localparam logic [2:0] CFG_RTC   = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam int CTL_B_LSB   = 8;
  localparam int CTL_OVR_BIT = 6;
  localparam int HALF_STRIDE = 8;
  localparam int TO_BIT      = 0;
  localparam int CM_BIT      = 1;
  localparam int RTC_BIT     = 3;

  // ************************************************************
  // Reset values and clock divider
  // ************************************************************
  localparam logic [15:0] CNT_RST   = 16'hFFFF;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [15:0] RTC_START = 16'h0001;
  localparam int RTC_IN_HZ  = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV    = RTC_IN_HZ / RTC_OUT_HZ;
  localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_DIV - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_OFF, MODE_ONESHOT, MODE_PERIODIC, MODE_CAPTURE
  } dht_mode_e;
  typedef enum logic [1:0] {
    EDGE_RISE, EDGE_FALL, EDGE_NONE, EDGE_BOTH
  } dht_edge_e;
  typedef struct packed {
    logic      half_capture_mode;
    dht_mode_e half_mode_field;
  } dht_mode_s;
  typedef struct packed {
    logic      half_conv_trigger_en;
    dht_edge_e half_edge_select;
    logic      half_debug_freeze;
    logic      half_enable;
  } dht_ctl_s;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dht_bus_s;

endpackage

// file: testbench/dht_timer_tb.sv
// Testbench: register-level checks of the dual half timer
`timescale 1ns/1ns
module dht_timer_tb;
  import dht_pkg::*;
  logic        ref_clk;
  logic        rst;
  dht_bus_s    bus_req;
  logic [31:0] bus_rdata;
  logic        capture_pin_a;
  logic        capture_pin_b;
  logic        debug_halt;
  logic        conv_trigger;
  logic        int_req;
  int          fails;
  int          checks;
  int          cyc;
  int          t0;
  int          p;
  logic        seen;
  logic [31:0] rv;

  dht_timer u_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b), .debug_halt(debug_halt),
    .conv_trigger(conv_trigger), .int_req(int_req));

  // ********
  // Clock and cycle count
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc++;

  // Comparison with four-state equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle strobes, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk) bus_req <= '0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk) bus_req <= '0;
    #1 rv = bus_rdata; // Data stands only in this cycle
    chk(nm, e, rv);
  endtask
  // Bounded wait for a trigger pulse; notes the cycle it came in
  task automatic wtrig;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge ref_clk);
      #1 seen = (conv_trigger === 1'b1);
    end
    t0 = cyc;
  endtask
  // Both pins (B high bit) held five cycles, well above the two-cycle minimum
  task automatic pin(input logic [1:0] v);
    @(posedge ref_clk) {capture_pin_b, capture_pin_a} <= v;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cut a hang short well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end

  // ********
  // Tests
  // ********
  initial begin
    bus_req = '0;
    rst = 1'b1;
    capture_pin_a = 1'b0;
    capture_pin_b = 1'b0;
    debug_halt = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rc("count", CNT_A_OFS, 32'hFFFF_FFFF);
    rc("load", ILR_A_OFS, 32'hFFFF_FFFF);
    rc("prescale", PRE_A_OFS, 32'h0000_0000);
    rc("control", CTL_OFS, 32'h0000_0000);
    rc("unmapped", 8'hF0, 32'h0000_0000);
    $display("test reset done");
    // Joined periodic: load 2 gives a three-cycle period
    wr(ILR_A_OFS, 32'h0003_0004);
    rc("joined count", CNT_A_OFS, 32'h0003_0004);
    wr(ILR_A_OFS, 32'h0000_0002);
    wr(MODE_A_OFS, 32'h0000_0002);
    wr(MASK_OFS, 32'h0000_0001);
    wr(CTL_OFS, 32'h0000_0011);
    wtrig();
    p = t0;
    wtrig();
    chk("period", 32'd3, 32'(t0 - p));
    wr(CTL_OFS, 32'h0000_0000);
    rc("raw", RAW_OFS, 32'h0000_0001);
    rc("masked", MIS_OFS, 32'h0000_0001);
    chk("irq", 32'h1, {31'h0, int_req});
    wr(CLR_OFS, 32'h0000_0001);
    rc("raw clr", RAW_OFS, 32'h0000_0000);
    chk("irq clr", 32'h0, {31'h0, int_req});
    $display("test joined periodic done");
    // One-shot stops reloaded and drops its own enable
    wr(MODE_A_OFS, 32'h0000_0001);
    wr(ILR_A_OFS, 32'h0000_0005);
    wr(CTL_OFS, 32'h0000_0011);
    wtrig();
    rc("oneshot ctl", CTL_OFS, 32'h0000_0010);
    rc("oneshot cnt", CNT_A_OFS, 32'h0000_0005);
    // Without trigger enable no pulse, but the flag still sets
    wr(CLR_OFS, 32'h0000_0001);
    wr(CTL_OFS, 32'h0000_0001);
    wtrig();
    chk("no trigger", 32'h0, {31'h0, seen});
    rc("raw again", RAW_OFS, 32'h0000_0001);
    wr(CLR_OFS, 32'h0000_0001);
    $display("test oneshot done");
    // Freeze under halt, then a load while running
    wr(MODE_A_OFS, 32'h0000_0002);
    wr(ILR_A_OFS, 32'h0000_1000);
    @(posedge ref_clk) debug_halt <= 1'b1;
    wr(CTL_OFS, 32'h0000_0003);
    rc("frozen", CNT_A_OFS, 32'h0000_1000);
    @(posedge ref_clk) debug_halt <= 1'b0;
    wr(ILR_A_OFS, 32'h0000_0100);
    rc("reload run", CNT_A_OFS, 32'h0000_00FF);
    wr(CTL_OFS, 32'h0000_0000);
    $display("test freeze done");
    // Split: load 3 with prescale 1 gives eight cycles
    wr(CFG_OFS, 32'h0000_0004);
    wr(ILR_A_OFS, 32'h0000_0003);
    wr(PRE_A_OFS, 32'h0000_0001);
    wr(CTL_OFS, 32'h0000_0011);
    wtrig();
    p = t0;
    wtrig();
    chk("split period", 32'd8, 32'(t0 - p));
    wr(CTL_OFS, 32'h0000_0000);
    wr(CLR_OFS, 32'h0000_0001);
    // Edge count: A falls 4 to match 2, B both edges 5 to match 3; two edges each
    wr(MODE_A_OFS, 32'h0000_0003);
    wr(ILR_A_OFS, 32'h0000_0004);
    wr(MATCH_A_OFS, 32'h0000_0002);
    wr(MODE_B_OFS, 32'h0000_0003);
    wr(ILR_B_OFS, 32'h0000_0005);
    wr(MATCH_B_OFS, 32'h0000_0003);
    wr(CTL_OFS, 32'h0000_0D05);
    for (int i = 0; i < 3; i++) begin
      pin(2'b11);
      pin(2'b00);
    end
    rc("edge raw", RAW_OFS, 32'h0000_0202);
    rc("edge cnt a", CNT_A_OFS, 32'h0000_0004);
    rc("edge cnt", CNT_B_OFS, 32'h0000_0005);
    rc("edge ctl", CTL_OFS, 32'h0000_0C04);
    $display("test split done");
    // First selection of clock mode starts the count at one
    wr(CFG_OFS, 32'h0000_0001);
    rc("clock start", CNT_A_OFS, 32'h0000_0001);
    $display("test clock done");
    test_done();
  end
endmodule
